// [src/adcseq_pkg.sv]
// ============================================================
// Shared constants and types of the conversion sequencer
// ============================================================
package adcseq_pkg;

	// ============================================================
	// Register map, one byte per index
	// ============================================================
	localparam int          ADDR_W       = 3;
	localparam logic [2:0]  REG_CONTROL  = 3'h0;    // Channel, go/busy, enable
	localparam logic [2:0]  REG_TIMING   = 3'h1;    // Justify, acquisition, clock
	localparam logic [2:0]  REG_RES_HIGH = 3'h2;    // Result high byte
	localparam logic [2:0]  REG_RES_LOW  = 3'h3;    // Result low byte
	localparam logic [2:0]  REG_FLAG     = 3'h4;    // Conversion done flag

	// Field positions
	localparam int BIT_ENABLE   = 0;
	localparam int BIT_GO       = 1;
	localparam int CHAN_LSB     = 2;
	localparam int CLKSEL_LSB   = 0;
	localparam int ACQ_LSB      = 3;
	localparam int BIT_JUSTIFY  = 7;
	localparam int BIT_DONE     = 0;

	// Reset and start values
	localparam logic [7:0]  RESULT_RST   = 8'h00;
	localparam logic [9:0]  TRIAL_INIT   = 10'h200;   // Mid-scale first guess
	localparam logic [9:0]  TRIAL_RST    = 10'h000;

	// Codes
	localparam logic [3:0]  CHAN_LAST    = 4'hc;      // Highest analog input
	localparam logic [3:0]  CHAN_FIXED   = 4'hf;      // Fixed reference
	localparam logic [1:0]  CLK_RC       = 2'h3;      // Low bits of RC clock code
	localparam logic [2:0]  ACQ_ZERO     = 3'h0;

	// Timing counts
	localparam logic [7:0]  INSTR_CLKS   = 8'h04;     // Clocks per instruction cycle
	localparam logic [7:0]  CONV_LAST    = 8'h0a;     // Eleven periods: 0..10
	localparam logic [7:0]  POST_LAST    = 8'h01;     // Two periods after a conversion
	localparam logic [7:0]  CNT_ZERO     = 8'h00;
	localparam logic [7:0]  CNT_ONE      = 8'h01;

	// Signals towards the sample-and-hold and capacitor array
	typedef struct packed {
		logic        powered;    // Converter biased
		logic        sample;     // Channel tied to holding capacitor
		logic        discharge;  // Capacitor array discharge
		logic        hold;       // Conversion in progress
		logic        fixed_ref;  // Fixed reference routed to the input
		logic [3:0]  channel;    // Selected input
		logic [9:0]  trial;      // Trial code for the comparator
	} adcseq_analog_t;

	// System clock divisor for each clock code
	function automatic logic [6:0] adcseq_tad_div(input logic [2:0] sel);
		case (sel)
			3'h0:    adcseq_tad_div = 7'h02;
			3'h1:    adcseq_tad_div = 7'h08;
			3'h2:    adcseq_tad_div = 7'h20;
			3'h4:    adcseq_tad_div = 7'h04;
			3'h5:    adcseq_tad_div = 7'h10;
			3'h6:    adcseq_tad_div = 7'h40;
			default: adcseq_tad_div = 7'h02;
		endcase
	endfunction : adcseq_tad_div

	// Acquisition length in periods for each code
	function automatic logic [7:0] adcseq_acq_tads(input logic [2:0] sel);
		case (sel)
			3'h1:    adcseq_acq_tads = 8'h02;
			3'h2:    adcseq_acq_tads = 8'h04;
			3'h3:    adcseq_acq_tads = 8'h06;
			3'h4:    adcseq_acq_tads = 8'h08;
			3'h5:    adcseq_acq_tads = 8'h0c;
			3'h6:    adcseq_acq_tads = 8'h10;
			3'h7:    adcseq_acq_tads = 8'h14;
			default: adcseq_acq_tads = 8'h00;
		endcase
	endfunction : adcseq_acq_tads

endpackage : adcseq_pkg

// [src/adcseq_tad_gen.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Period tick generator: system clock divider or RC clock pin
// ============================================================
module adcseq_tad_gen
	import adcseq_pkg::*;
(
	input  wire logic        clock_i,    // System clock
	input  wire logic        rst_i,      // Synchronous reset
	input  wire logic        ce_i,       // Clock enable
	input  wire logic        run_i,      // Count only while high
	input  wire logic [2:0]  clk_sel_i,  // Conversion clock code
	input  wire logic        rc_clk_i,   // Dedicated RC oscillator pin
	output logic             tick_o      // One-cycle period tick
);

	logic        rc_s1_q;     // Synchroniser first stage
	logic        rc_s2_q;     // Synchroniser second stage
	logic        rc_s3_q;     // Edge history
	logic [6:0]  div_q;       // Divider count
	logic [6:0]  div_d;
	logic        tick_d;

	wire         rc_mode  = (clk_sel_i[1:0] == CLK_RC);
	wire         rc_rise  = rc_s2_q & ~rc_s3_q;
	wire  [6:0]  div_last = adcseq_tad_div(clk_sel_i) - 7'h01;
	wire         div_wrap = (div_q == div_last);

	// Next divider state and tick
	always_comb begin
		div_d  = div_q;
		tick_d = 1'b0;
		if (!run_i) begin
			div_d = 7'h00;
		end else if (rc_mode) begin
			tick_d = rc_rise;
		end else if (div_wrap) begin
			div_d  = 7'h00;
			tick_d = 1'b1;
		end else begin
			div_d = div_q + 7'h01;
		end
	end

	// Pin synchroniser, divider and tick register
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			rc_s1_q <= 1'b0;
			rc_s2_q <= 1'b0;
			rc_s3_q <= 1'b0;
			div_q   <= 7'h00;
			tick_o  <= 1'b0;
		end else if (ce_i) begin
			rc_s1_q <= rc_clk_i;
			rc_s2_q <= rc_s1_q;
			rc_s3_q <= rc_s2_q;
			div_q   <= div_d;
			tick_o  <= tick_d;
		end
	end

endmodule : adcseq_tad_gen
`default_nettype wire

// [src/adcseq_sequencer.sv]
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Conversion sequencer of a 10-bit successive approximation converter
// ============================================================
// Notes on behaviour
// - Converter runs only while enable bit set
// - Go starts now, or after acquisition delay
// - Code 010 samples four periods first
// - Zero delay: start after next instruction
// - Completion clears go, sets flag, loads result
// - Clearing go aborts; result kept intact
// - Reset returns all registers, stops conversion
// - Two periods wait, then channel reconnects
// - Capacitor array discharged after each sample
// - RC clock adds one instruction start delay
// - RC in sleep: wake or power down
// - Other clocks: sleep aborts and powers down
// - Compare trigger sets go, clears timer
// - Channel codes: inputs 0-12, fixed reference
// - Go reads one while converting
// - Enable low holds converter unpowered
// - Acquisition codes: 0,2,4,6,8,12,16,20 periods
// - Clock codes: divided system clock or RC
// - Conversion lasts eleven periods
// - Justify bit picks right or left alignment
module adcseq_sequencer
	import adcseq_pkg::*;
(
	input  wire logic               clock_i,        // System clock, 20 MHz
	input  wire logic               rst_i,          // Synchronous reset
	input  wire logic               ce_i,           // Clock enable
	input  wire logic [ADDR_W-1:0]  addr_i,         // Register index
	input  wire logic [7:0]         wdata_i,        // Write data
	input  wire logic               wr_i,           // Write strobe
	input  wire logic               rd_i,           // Read strobe
	output logic      [7:0]         rdata_o,        // Read data, next cycle
	input  wire logic               sleep_i,        // Core is in sleep
	input  wire logic               irq_enable_i,   // Converter interrupt enabled
	input  wire logic               trigger_i,      // Compare unit two event
	input  wire logic               rc_clk_i,       // RC oscillator pin
	input  wire logic               comp_i,         // Comparator pin
	output adcseq_analog_t          analog_o,       // Controls to the analog side
	output logic                    done_flag_o,    // Conversion done flag
	output logic                    wake_o,         // Wake request pulse
	output logic                    timer_clear_o   // Timer counter clear pulse
);

	// ============================================================
	// State and registers
	// ============================================================
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,   // Sampling or off
		ST_WAIT = 5'h02,   // Instruction delay before start
		ST_ACQ  = 5'h04,   // Programmed acquisition
		ST_CONV = 5'h08,   // Bit decisions
		ST_POST = 5'h10    // Discharge and wait
	} adcseq_state_t;

	adcseq_state_t   state_q, state_d;     // Sequencer state
	logic [7:0]      cnt_q, cnt_d;         // Clock or period count
	logic            en_q, en_d;           // Converter enable
	logic            go_q, go_d;           // Go / busy
	logic [3:0]      chan_q, chan_d;       // Channel select
	logic            just_q, just_d;       // Result justify
	logic [2:0]      acq_q, acq_d;         // Acquisition select
	logic [2:0]      clk_q, clk_d;         // Conversion clock select
	logic [7:0]      res_hi_q, res_hi_d;   // Result high
	logic [7:0]      res_lo_q, res_lo_d;   // Result low
	logic            flag_q, flag_d;       // Done flag
	logic [9:0]      trial_q, trial_d;     // Approximation register
	logic            off_q, off_d;         // Sleep power down
	logic            comp_s1_q;            // Comparator synchroniser first stage
	logic            comp_s2_q;            // Comparator synchroniser second stage
	adcseq_analog_t  analog_d;             // Next analog controls
	logic            tick;                 // Period tick

	// ============================================================
	// Helper functions
	// ============================================================
	// One successive approximation step at period count c
	function automatic logic [9:0] sar_step(input logic [9:0] t, input logic [7:0] c,
	                                        input logic cmp);
		logic [9:0] r;
		logic [3:0] b;
		r = t;
		b = 4'(CONV_LAST - c);
		r[b] = cmp;
		if (b != 4'h0) begin
			r[b - 4'h1] = 1'b1;
		end
		sar_step = r;
	endfunction : sar_step

	// Result placed as {high, low}
	function automatic logic [15:0] fmt_result(input logic [9:0] r, input logic right);
		fmt_result = right ? {6'h00, r} : {r, 6'h00};
	endfunction : fmt_result

	// ============================================================
	// Decoding
	// ============================================================
	wire wr_ctrl   = wr_i && (addr_i == REG_CONTROL);
	wire wr_timing = wr_i && (addr_i == REG_TIMING);
	wire wr_hi     = wr_i && (addr_i == REG_RES_HIGH);
	wire wr_lo     = wr_i && (addr_i == REG_RES_LOW);
	wire wr_flag   = wr_i && (addr_i == REG_FLAG);
	wire rc_mode   = (clk_q[1:0] == CLK_RC);
	wire acq_zero  = (acq_q == ACQ_ZERO);
	wire active    = (state_q == ST_WAIT) || (state_q == ST_ACQ) || (state_q == ST_CONV);
	// Go only counts when the converter was already enabled
	wire go_write1 = wr_ctrl && wdata_i[BIT_GO] && en_q;
	wire go_write0 = wr_ctrl && !wdata_i[BIT_GO];
	wire trig_set  = trigger_i && en_q;
	wire complete  = (state_q == ST_CONV) && go_q && en_q && tick && (cnt_q == CONV_LAST);
	wire sl_abort  = sleep_i && !rc_mode && active;
	wire [7:0] acq_last   = adcseq_acq_tads(acq_q) - CNT_ONE;
	// Start delay: one instruction for zero acquisition, one more for RC
	wire [7:0] start_clks = (acq_zero ? INSTR_CLKS : CNT_ZERO)
	                      + (rc_mode ? INSTR_CLKS : CNT_ZERO);
	wire [9:0]  trial_nx  = sar_step(trial_q, cnt_q, comp_s2_q);
	wire [15:0] res_fmt   = fmt_result(trial_nx, just_q);
	wire chan_ok   = (chan_q <= CHAN_LAST) || (chan_q == CHAN_FIXED);
	wire tad_run   = (state_q == ST_ACQ) || (state_q == ST_CONV) || (state_q == ST_POST);

	// Read multiplexer; unmapped indices read zero
	wire [7:0] rd_mux =
		(addr_i == REG_CONTROL)  ? {2'h0, chan_q, go_q, en_q} :
		(addr_i == REG_TIMING)   ? {just_q, 1'b0, acq_q, clk_q} :
		(addr_i == REG_RES_HIGH) ? res_hi_q :
		(addr_i == REG_RES_LOW)  ? res_lo_q :
		(addr_i == REG_FLAG)     ? {7'h00, flag_q} : 8'h00;

	// ============================================================
	// Period tick generator
	// ============================================================
	adcseq_tad_gen u_tad (
		.clock_i   (clock_i),
		.rst_i     (rst_i),
		.ce_i      (ce_i),
		.run_i     (tad_run),
		.clk_sel_i (clk_q),
		.rc_clk_i  (rc_clk_i),
		.tick_o    (tick)
	);

	// ============================================================
	// Register updates
	// ============================================================
	always_comb begin
		en_d   = wr_ctrl ? wdata_i[BIT_ENABLE] : en_q;
		chan_d = wr_ctrl ? wdata_i[CHAN_LSB +: 4] : chan_q;
		just_d = wr_timing ? wdata_i[BIT_JUSTIFY] : just_q;
		acq_d  = wr_timing ? wdata_i[ACQ_LSB +: 3] : acq_q;
		clk_d  = wr_timing ? wdata_i[CLKSEL_LSB +: 3] : clk_q;
		// Hardware set of go wins over any clear in the same cycle
		if (go_write1 || trig_set) begin
			go_d = 1'b1;
		end else if (complete || go_write0 || sl_abort || !en_q) begin
			go_d = 1'b0;
		end else begin
			go_d = go_q;
		end
		// Completion loads both result bytes; abort leaves them alone
		if (complete) begin
			res_hi_d = res_fmt[15:8];
			res_lo_d = res_fmt[7:0];
		end else begin
			res_hi_d = wr_hi ? wdata_i : res_hi_q;
			res_lo_d = wr_lo ? wdata_i : res_lo_q;
		end
		// Done flag: set wins over a software clear
		flag_d = complete || (flag_q && !(wr_flag && !wdata_i[BIT_DONE]));
		// Sleep power down, left set until sleep ends
		off_d  = sleep_i && (off_q || !rc_mode || (complete && !irq_enable_i));
	end

	// ============================================================
	// Sequencer
	// ============================================================
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		trial_d = trial_q;
		unique case (state_q)
			ST_IDLE: begin
				if (en_q && go_q) begin
					cnt_d = CNT_ZERO;
					if (start_clks != CNT_ZERO) begin
						state_d = ST_WAIT;
						cnt_d   = start_clks - CNT_ONE;
					end else begin
						state_d = ST_ACQ;
					end
				end
			end
			ST_WAIT: begin
				if (!go_q) begin
					state_d = ST_POST;
					cnt_d   = CNT_ZERO;
				end else if (cnt_q == CNT_ZERO) begin
					state_d = acq_zero ? ST_CONV : ST_ACQ;
					trial_d = TRIAL_INIT;
				end else begin
					cnt_d = cnt_q - CNT_ONE;
				end
			end
			ST_ACQ: begin
				if (!go_q) begin
					state_d = ST_POST;
					cnt_d   = CNT_ZERO;
				end else if (tick && cnt_q == acq_last) begin
					state_d = ST_CONV;
					cnt_d   = CNT_ZERO;
					trial_d = TRIAL_INIT;
				end else if (tick) begin
					cnt_d = cnt_q + CNT_ONE;
				end
			end
			ST_CONV: begin
				if (!go_q) begin
					state_d = ST_POST;
					cnt_d   = CNT_ZERO;
				end else if (complete) begin
					state_d = ST_POST;
					cnt_d   = CNT_ZERO;
					trial_d = trial_nx;
				end else if (tick) begin
					cnt_d = cnt_q + CNT_ONE;
					// Period 0 holds the sample, then one bit per period
					if (cnt_q != CNT_ZERO) begin
						trial_d = trial_nx;
					end
				end
			end
			ST_POST: begin
				if (tick && cnt_q == POST_LAST) begin
					state_d = ST_IDLE;
					cnt_d   = CNT_ZERO;
				end else if (tick) begin
					cnt_d = cnt_q + CNT_ONE;
				end
			end
			default: begin
				state_d = ST_IDLE;
				cnt_d   = CNT_ZERO;
			end
		endcase
		// Disabled converter stays idle
		if (!en_q) begin
			state_d = ST_IDLE;
			cnt_d   = CNT_ZERO;
		end
	end

	// Analog controls
	always_comb begin
		analog_d.powered   = en_q && !off_q;
		analog_d.sample    = analog_d.powered && chan_ok &&
		                     (state_q == ST_IDLE || state_q == ST_WAIT || state_q == ST_ACQ);
		analog_d.discharge = analog_d.powered && (state_q == ST_POST);
		analog_d.hold      = analog_d.powered && (state_q == ST_CONV);
		analog_d.fixed_ref = (chan_q == CHAN_FIXED);
		analog_d.channel   = chan_q;
		analog_d.trial     = trial_q;
	end

	// ============================================================
	// Flip-flops
	// ============================================================
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state_q   <= ST_IDLE;
			cnt_q     <= CNT_ZERO;
			en_q      <= 1'b0;
			go_q      <= 1'b0;
			chan_q    <= 4'h0;
			just_q    <= 1'b0;
			acq_q     <= ACQ_ZERO;
			clk_q     <= 3'h0;
			res_hi_q  <= RESULT_RST;
			res_lo_q  <= RESULT_RST;
			flag_q    <= 1'b0;
			trial_q   <= TRIAL_RST;
			off_q     <= 1'b0;
			comp_s1_q <= 1'b0;
			comp_s2_q <= 1'b0;
		end else if (ce_i) begin
			state_q   <= state_d;
			cnt_q     <= cnt_d;
			en_q      <= en_d;
			go_q      <= go_d;
			chan_q    <= chan_d;
			just_q    <= just_d;
			acq_q     <= acq_d;
			clk_q     <= clk_d;
			res_hi_q  <= res_hi_d;
			res_lo_q  <= res_lo_d;
			flag_q    <= flag_d;
			trial_q   <= trial_d;
			off_q     <= off_d;
			comp_s1_q <= comp_i;
			comp_s2_q <= comp_s1_q;
		end
	end

	// Output registers
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			rdata_o       <= 8'h00;
			analog_o      <= '0;
			done_flag_o   <= 1'b0;
			wake_o        <= 1'b0;
			timer_clear_o <= 1'b0;
		end else if (ce_i) begin
			rdata_o       <= rd_i ? rd_mux : 8'h00;
			analog_o      <= analog_d;
			done_flag_o   <= flag_d;
			wake_o        <= complete && sleep_i && irq_enable_i;
			timer_clear_o <= trigger_i;
		end
	end

	// ============================================================
	// Assertions
	// ============================================================
	a_done_clears_go: assert property (@(posedge clock_i) disable iff (rst_i)
		ce_i && complete && !go_write1 && !trig_set |=> !go_q && flag_q)
		else $error("completion did not clear go or set flag");

	a_abort_keeps_res: assert property (@(posedge clock_i) disable iff (rst_i)
		ce_i && active && !go_q && !wr_hi && !wr_lo |=> $stable(res_hi_q) && $stable(res_lo_q))
		else $error("abort changed result");

	a_off_unpowered: assert property (@(posedge clock_i) disable iff (rst_i)
		ce_i && !en_q |=> !analog_o.powered && state_q == ST_IDLE)
		else $error("disabled converter powered");

	a_post_two_tad: assert property (@(posedge clock_i) disable iff (rst_i)
		ce_i && en_q && state_q == ST_POST && tick && cnt_q == POST_LAST |=> state_q == ST_IDLE)
		else $error("post wait length wrong");

	a_conv_eleven: assert property (@(posedge clock_i) disable iff (rst_i)
		ce_i && state_q == ST_CONV && go_q && en_q && tick && cnt_q == CONV_LAST
		|=> state_q == ST_POST)
		else $error("conversion length wrong");

	a_zero_acq_wait: assert property (@(posedge clock_i) disable iff (rst_i)
		ce_i && en_q && go_q && state_q == ST_IDLE && acq_zero |=> state_q == ST_WAIT)
		else $error("zero delay start not deferred");

	a_trig_sets_go: assert property (@(posedge clock_i) disable iff (rst_i)
		ce_i && trigger_i && en_q |=> go_q && timer_clear_o)
		else $error("trigger missed");

	a_sleep_abort: assert property (@(posedge clock_i) disable iff (rst_i)
		ce_i && sl_abort && !go_write1 && !trig_set |=> !go_q ##1 !analog_o.powered)
		else $error("sleep did not abort");

	a_discharge_post: assert property (@(posedge clock_i) disable iff (rst_i)
		ce_i && state_q == ST_POST && en_q && !off_q |=> analog_o.discharge && !analog_o.sample)
		else $error("no discharge after sample");

endmodule : adcseq_sequencer
`default_nettype wire

// [verif/adcseq_analog_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Analog side: channel level against trial code, RC oscillator
// ============================================================
module adcseq_analog_model
	import adcseq_pkg::*;
(
	input  wire adcseq_analog_t  analog_i,  // Controls from the sequencer
	output logic                 comp_o,    // Comparator result
	output logic                 rc_clk_o   // Dedicated oscillator, free running
);
	logic [9:0] level;  // Input level, one per channel
	// Each channel converts to its own code
	assign level = {analog_i.channel, 6'h2d};
	// Comparator only meaningful while holding, else a changing pattern
	assign comp_o = analog_i.hold ? (level >= analog_i.trial) : rc_clk_o;
	// Oscillator edges fall on falling edges of the system clock
	initial begin
		rc_clk_o = 1'b0;
		forever #350 rc_clk_o = ~rc_clk_o;
	end
endmodule : adcseq_analog_model
`default_nettype wire

// [verif/adcseq_sequencer_bench.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Self-checking bench of the conversion sequencer
// ============================================================
module adcseq_sequencer_bench
	import adcseq_pkg::*;
	;
	logic            clock_i, rst_i, wr_i, rd_i, sleep_i, irq_enable_i, trigger_i;
	logic [2:0]      addr_i;
	logic [7:0]      wdata_i, rdata_o;
	logic            rc_clk, comp, done_flag_o, wake_o, timer_clear_o, wake_seen;
	adcseq_analog_t  analog;
	int              err_count, tests_run, cycles, n;

	adcseq_sequencer u_adcseq_sequencer (.clock_i(clock_i), .rst_i(rst_i), .ce_i(1'b1),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.sleep_i(sleep_i), .irq_enable_i(irq_enable_i), .trigger_i(trigger_i),
		.rc_clk_i(rc_clk), .comp_i(comp), .analog_o(analog), .done_flag_o(done_flag_o),
		.wake_o(wake_o), .timer_clear_o(timer_clear_o));
	adcseq_analog_model u_adcseq_analog_model (.analog_i(analog), .comp_o(comp),
		.rc_clk_o(rc_clk));

	// ============================================================
	// Clock and hang guard
	// ============================================================
	initial begin
		clock_i = 1'b0;
		forever #25 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			err_count++;
			print_verdict();
		end
	end

	// ============================================================
	// Shared tasks
	// ============================================================
	task automatic print_verdict;
		$display("Counts: %0d mismatches in %0d comparisons", err_count, tests_run);
		if (err_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : print_verdict
	task automatic check(input logic [19:0] seen, input logic [19:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic idle(input int k);
		repeat (k) @(posedge clock_i);
	endtask : idle
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
		@(posedge clock_i);
	endtask : wr
	// Read data is looked at in the one cycle it stands
	task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		@(negedge clock_i);
		check(rdata_o, exp);
		@(posedge clock_i);
	endtask : rd_chk
	// Count cycles until the done flag rises, noting any wake pulse
	task automatic wait_done;
		n = 0;
		wake_seen = 1'b0;
		do begin
			@(negedge clock_i);
			wake_seen |= wake_o;
			n++;
		end while (done_flag_o !== 1'b1 && n < 3000);
		@(posedge clock_i);
	endtask : wait_done

	// ============================================================
	// Scenarios
	// ============================================================
	task automatic t_convert(input logic [7:0] tim, input logic [7:0] ctl, input int lo,
		input int hi, input logic [7:0] res_h, input logic [7:0] res_l);
		wr(REG_FLAG, 8'h00);
		wr(REG_TIMING, tim);
		// Channel picked and sampled for over 16 us before go
		wr(REG_CONTROL, ctl & 8'hfd);
		idle(320);
		wr(REG_CONTROL, ctl);
		rd_chk(REG_CONTROL, ctl);
		wait_done();
		check(n >= lo && n <= hi, 1'b1);
		@(negedge clock_i);
		check({analog.discharge, analog.sample}, 2'h2);
		@(posedge clock_i);
		rd_chk(REG_CONTROL, ctl & 8'hfd);
		rd_chk(REG_FLAG, 8'h01);
		rd_chk(REG_RES_HIGH, res_h);
		rd_chk(REG_RES_LOW, res_l);
		idle(80);
		@(negedge clock_i);
		check({analog.sample, analog.fixed_ref}, {1'b1, ctl[5:2] == CHAN_FIXED});
		@(posedge clock_i);
	endtask : t_convert
	task automatic t_abort;
		wr(REG_FLAG, 8'h00);
		wr(REG_TIMING, 8'h06);
		wr(REG_CONTROL, 8'h33);
		idle(100);
		wr(REG_CONTROL, 8'h31);
		idle(300);
		rd_chk(REG_RES_HIGH, 8'hfb);
		rd_chk(REG_RES_LOW, 8'h40);
		rd_chk(REG_FLAG, 8'h00);
		rd_chk(REG_CONTROL, 8'h31);
	endtask : t_abort
	task automatic t_trigger;
		trigger_i <= 1'b1;
		@(posedge clock_i);
		trigger_i <= 1'b0;
		@(negedge clock_i);
		check(timer_clear_o, 1'b1);
		@(posedge clock_i);
		rd_chk(REG_CONTROL, 8'h33);
		wr(REG_CONTROL, 8'h31);
		idle(200);
	endtask : t_trigger
	task automatic t_sleep;
		wr(REG_CONTROL, 8'h33);
		idle(20);
		sleep_i <= 1'b1;
		idle(4);
		rd_chk(REG_CONTROL, 8'h31);
		@(negedge clock_i);
		check(analog.powered, 1'b0);
		@(posedge clock_i);
		sleep_i <= 1'b0;
		idle(200);
	endtask : t_sleep
	// Sleep is entered right after the go write, before the start delay ends
	task automatic t_rc(input logic irq);
		wr(REG_FLAG, 8'h00);
		wr(REG_TIMING, 8'h83);
		irq_enable_i <= irq;
		wr(REG_CONTROL, 8'h33);
		sleep_i <= 1'b1;
		wait_done();
		check(wake_seen, irq);
		@(negedge clock_i);
		check(analog.powered, irq);
		@(posedge clock_i);
		sleep_i <= 1'b0;
		rd_chk(REG_CONTROL, 8'h31);
		rd_chk(REG_RES_LOW, 8'h2d);
		idle(100);
	endtask : t_rc

	// ============================================================
	// Main sequence
	// ============================================================
	initial begin
		{rst_i, wr_i, rd_i, sleep_i, irq_enable_i, trigger_i} = 6'h20;
		{addr_i, wdata_i} = 11'h000;
		{err_count, tests_run, cycles} = '0;
		repeat (20) @(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i);
		for (int a = 0; a < 8; a++)
			rd_chk(a[2:0], 8'h00);
		check(analog, '0);
		wr(REG_CONTROL, 8'h03);
		rd_chk(REG_CONTROL, 8'h01);
		t_convert(8'h85, 8'h33, 177, 185, 8'h03, 8'h2d);
		t_convert(8'h15, 8'h3f, 237, 245, 8'hfb, 8'h40);
		t_abort();
		t_trigger();
		t_sleep();
		t_rc(1'b1);
		t_rc(1'b0);
		// Reserved channel code: powered but never tied to the capacitor
		wr(REG_CONTROL, 8'h35);
		@(negedge clock_i);
		check(analog.sample, 1'b0);
		@(posedge clock_i);
		wr(REG_CONTROL, 8'h00);
		rd_chk(REG_CONTROL, 8'h00);
		check(analog.powered, 1'b0);
		print_verdict();
	end
endmodule : adcseq_sequencer_bench
`default_nettype wire
